// ===== rtl/remote_serial_status_unit_defs.vh
/*
  Constants for the remote serial status unit: event flag positions,
  reset values, error codes, speed and handshake encodings, timing.
  Assumes a 250 MHz system clock.
*/
`ifndef REMOTE_SERIAL_STATUS_UNIT_DEFS_VH
`define REMOTE_SERIAL_STATUS_UNIT_DEFS_VH

// Event flag bit positions
`define EVF_OP_DONE_BIT    0
`define EVF_CTRL_REQ_BIT   1
`define EVF_QUERY_BIT      2
`define EVF_DEVICE_BIT     3
`define EVF_RUN_FAULT_BIT  4
`define EVF_COMMAND_BIT    5
`define EVF_USER_REQ_BIT   6
`define EVF_POWER_ON_BIT   7

// Unused flag bits read as zero
`define EVF_USED_MASK      8'hBD
// Power-on flag kept on clears
`define EVF_KEEP_MASK      8'h80
`define EVF_RESET          8'h80
`define EVM_RESET          8'h00

// Event summary position in status byte
`define STB_SUMMARY_BIT    5

// Error codes
`define ERR_NONE           8'h00
`define ERR_OUT_OF_RANGE   8'h86
`define ERR_INPUT_FULL     8'hB5
`define ARG_MAX            16'h00FF

// Speed codes: 0=1200 1=2400 2=4800 3=9600
`define SPEED_1200         2'h0
`define SPEED_2400         2'h1
`define SPEED_4800         2'h2
`define SPEED_9600         2'h3
`define SPEED_DEFAULT      2'h3
`define HS_NONE            1'b0
`define HS_RTS_CTS         1'b1

// Bit periods in ns, and cycles at 4 ns per clock
`define CLK_PERIOD_NS      4
`define BIT_NS_1200        833333
`define BIT_NS_2400        416667
`define BIT_NS_4800        208333
`define BIT_NS_9600        104167
// Bit period in clocks, sized to the 20-bit counter value
`define BIT_CYC_1200       20'h32DCD
`define BIT_CYC_2400       20'h196E6
`define BIT_CYC_4800       20'h0CB73
`define BIT_CYC_9600       20'h065B9

`endif

// ===== rtl/remote_serial_status_unit.v
/*
  Remote serial status unit: serial speed and handshake selection with
  non-volatile storage port, RTS/CTS flow control around a two-entry
  receive buffer, remote/panel state with keypad lockout, event flags
  with enable mask and summary bit.
  Assumes a command decoder on the same clock pulses the command
  strobes, an external non-volatile store returns the saved settings
  after reset, and cts_in and panel keys are asynchronous pins.
*/
// Summary of operation
// - Serial speed selectable as 1200, 2400, 4800 or 9600 baud by menu.
// - Handshake selectable from menu: RTS/CTS or none.
// - Speed and handshake kept in non-volatile storage across power loss.
// - With RTS/CTS, RTS on means able to receive, off means not.
// - With RTS/CTS, transmit only while CTS is on.
// - Without handshake always accept and send; overflow reports buffer full; a word arriving at full in a pop cycle is dropped unreported.
// - Remote command enters remote state and lights the link LED.
// - In remote state panel controls are ignored except the release key.
// - Remote state ends on release command, release key or power cycle.
// - After lockout command the release key is ignored.
// - Status, mask and error commands work under panel control.
// - Event flag query returns the flags and then clears them; the code keeps bit 7 set.
// - Flags except bit 7 clear at power-on, clear status, parameter change.
// - Event flag bits 6 and 1 always read zero.
// - Command error sets event flag bit 5.
// - Query and execution errors set event flag bit 4.
// - Device-dependent error sets event flag bit 3.
// - Query error sets event flag bit 2.
// - Operation-complete command sets event flag bit 0.
// - Summary is OR of each flag ANDed with its mask bit.
// - Mask loads for 0 to 255, else unchanged and range error reported.
// - Mask query returns mask; all zero at power-on, clears but bit 7 on zero, change.
// - Input buffer overflow reports error code 181.
// - Out-of-range argument reports error code 134.
// - Event summary sits in status byte bit 5.
`timescale 1ns/1ns
`include "remote_serial_status_unit_defs.vh"

module remote_serial_status_unit #(
  parameter DATA_W = 8
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              resetn,
  // Menu settings
  input  wire              speed_menu_key,
  input  wire              handshake_menu_key,
  input  wire [1:0]        menu_speed,
  input  wire              menu_handshake,
  // Non-volatile store
  input  wire              nv_valid,
  input  wire [1:0]        nv_speed,
  input  wire              nv_handshake,
  output reg               nv_write,
  output reg  [1:0]        nv_speed_out,
  output reg               nv_handshake_out,
  // Serial link handshake lines
  input  wire              cts_in,
  output reg               rts_out,
  output reg  [1:0]        speed_sel,
  output reg               handshake_sel,
  output reg  [19:0]       bit_cycles,
  // Received characters
  input  wire              rx_valid,
  input  wire [DATA_W-1:0] rx_data,
  output reg               rx_ready,
  output reg               rx_out_valid,
  output reg  [DATA_W-1:0] rx_out_data,
  input  wire              rx_out_ready,
  // Transmit gate
  input  wire              tx_request,
  output reg               tx_enable,
  // Remote and panel control
  input  wire              remote_cmd,
  input  wire              release_to_panel_cmd,
  input  wire              keypad_lockout_cmd,
  input  wire              panel_release_key,
  input  wire [3:0]        panel_keys,
  output reg               link_active_led,
  output reg  [3:0]        panel_keys_out,
  // Status commands
  input  wire              clear_status_cmd,
  input  wire              flags_query_cmd,
  input  wire              mask_write_cmd,
  input  wire [15:0]       mask_arg,
  input  wire              mask_query_cmd,
  input  wire              op_complete_cmd,
  input  wire              command_error,
  input  wire              run_fault,
  input  wire              device_error,
  input  wire              query_error,
  output reg               reply_valid,
  output reg  [7:0]        reply_data,
  output reg               event_summary_bit,
  output reg  [7:0]        status_summary,
  output reg               error_valid,
  output reg  [7:0]        error_code
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [1:0] cts_sync_ff;
  reg [1:0] rel_sync_ff;
  reg [7:0] keys_sync_ff;
  reg       rel_prev_ff;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cts_sync_ff  <= 2'h0;
      rel_sync_ff  <= 2'h0;
      keys_sync_ff <= 8'h00;
      rel_prev_ff  <= 1'b0;
    end else begin
      cts_sync_ff  <= {cts_sync_ff[0], cts_in};
      rel_sync_ff  <= {rel_sync_ff[0], panel_release_key};
      keys_sync_ff <= {keys_sync_ff[3:0], panel_keys};
      rel_prev_ff  <= rel_sync_ff[1];
    end
  end

  wire cts_s      = cts_sync_ff[1];
  wire rel_press  = rel_sync_ff[1] & ~rel_prev_ff;

  //////////////////////////////////////////////////////////////////////////
  // Interface settings

  function [19:0] speed_cycles;
    input [1:0] code;
    begin
      case (code)
        `SPEED_1200: speed_cycles = `BIT_CYC_1200;
        `SPEED_2400: speed_cycles = `BIT_CYC_2400;
        `SPEED_4800: speed_cycles = `BIT_CYC_4800;
        default:     speed_cycles = `BIT_CYC_9600;
      endcase
    end
  endfunction

  reg        remote_ff;
  reg        lockout_ff;
  reg        loaded_ff;
  reg        param_change;

  always @* begin
    param_change = 1'b0;
    if (!remote_ff && (speed_menu_key || handshake_menu_key))
      param_change = 1'b1;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      speed_sel        <= `SPEED_DEFAULT;
      handshake_sel    <= `HS_NONE;
      bit_cycles       <= 20'h00000;
      loaded_ff        <= 1'b0;
      nv_write         <= 1'b0;
      nv_speed_out     <= `SPEED_DEFAULT;
      nv_handshake_out <= `HS_NONE;
    end else begin
      nv_write   <= 1'b0;
      bit_cycles <= speed_cycles(speed_sel);
      if (!loaded_ff && nv_valid) begin
        loaded_ff     <= 1'b1;
        speed_sel     <= nv_speed;
        handshake_sel <= nv_handshake;
      end else if (param_change) begin
        if (speed_menu_key) begin
          speed_sel    <= menu_speed;
          nv_speed_out <= menu_speed;
        end else begin
          nv_speed_out <= speed_sel;
        end
        if (handshake_menu_key) begin
          handshake_sel    <= menu_handshake;
          nv_handshake_out <= menu_handshake;
        end else begin
          nv_handshake_out <= handshake_sel;
        end
        nv_write <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive buffer, two entries

  reg [DATA_W-1:0] buf_ff [0:1];
  reg [1:0]        count_ff;
  reg              rd_ff;
  reg              wr_ff;
  reg              ovf_ff;

  wire buf_push = rx_valid && (count_ff != 2'h2);
  wire buf_pop  = rx_out_valid && rx_out_ready;
  wire [1:0] nxt_count = count_ff - {1'b0, buf_pop} + {1'b0, buf_push};

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_ff     <= 2'h0;
      rd_ff        <= 1'b0;
      wr_ff        <= 1'b0;
      ovf_ff       <= 1'b0;
      buf_ff[0]    <= {DATA_W{1'b0}};
      buf_ff[1]    <= {DATA_W{1'b0}};
      rx_ready     <= 1'b1;
      rx_out_valid <= 1'b0;
      rx_out_data  <= {DATA_W{1'b0}};
    end else begin
      ovf_ff <= rx_valid && (count_ff == 2'h2) && !buf_pop;
      if (buf_push) begin
        buf_ff[wr_ff] <= rx_data;
        wr_ff         <= ~wr_ff;
      end
      if (buf_pop)
        rd_ff <= ~rd_ff;
      case ({buf_push, buf_pop})
        2'b10:   count_ff <= count_ff + 2'h1;
        2'b01:   count_ff <= count_ff - 2'h1;
        default: count_ff <= count_ff;
      endcase
      rx_out_valid <= nxt_count != 2'h0;
      // Empty after pop: the arriving word goes straight to the head
      if ((count_ff - {1'b0, buf_pop}) == 2'h0)
        rx_out_data <= rx_data;
      else if (buf_pop)
        rx_out_data <= buf_ff[~rd_ff];
      else
        rx_out_data <= buf_ff[rd_ff];
      // Ready tracks the fill level after this edge, so no word is lost
      rx_ready <= nxt_count != 2'h2;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flow control lines

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rts_out   <= 1'b1;
      tx_enable <= 1'b0;
    end else if (handshake_sel == `HS_RTS_CTS) begin
      rts_out   <= (count_ff == 2'h0) ||
                   (count_ff == 2'h1 && !buf_push);
      tx_enable <= tx_request && cts_s;
    end else begin
      rts_out   <= 1'b1;
      tx_enable <= tx_request;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Remote and panel control

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      remote_ff       <= 1'b0;
      lockout_ff      <= 1'b0;
      link_active_led <= 1'b0;
      panel_keys_out  <= 4'h0;
    end else begin
      if (release_to_panel_cmd) begin
        remote_ff  <= 1'b0;
        lockout_ff <= 1'b0;
      end else if (remote_ff && rel_press && !lockout_ff) begin
        remote_ff <= 1'b0;
      end else if (remote_cmd) begin
        remote_ff <= 1'b1;
      end
      if (keypad_lockout_cmd)
        lockout_ff <= 1'b1;
      link_active_led <= remote_ff;
      panel_keys_out  <= remote_ff ? 4'h0 : keys_sync_ff[7:4];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event flags and mask

  reg  [7:0] flags_ff;
  reg  [7:0] mask_ff;
  reg  [7:0] ev_set;
  reg  [7:0] nxt_mask;
  wire       mask_ok   = mask_arg <= `ARG_MAX;
  wire       range_err = mask_write_cmd && !mask_ok;
  wire       flag_clr  = clear_status_cmd || flags_query_cmd || param_change;

  // Enabled flags folded into one summary bit
  function summary_of;
    input [7:0] flags;
    input [7:0] mask;
    begin
      summary_of = |(flags & mask);
    end
  endfunction

  always @* begin
    ev_set = 8'h00;
    ev_set[`EVF_COMMAND_BIT]   = command_error;
    ev_set[`EVF_RUN_FAULT_BIT] = run_fault || query_error ||
                                 range_err;
    ev_set[`EVF_DEVICE_BIT]    = device_error;
    ev_set[`EVF_QUERY_BIT]     = query_error;
    ev_set[`EVF_OP_DONE_BIT]   = op_complete_cmd;
  end

  // Zero write keeps the power-on enable bit, like a parameter change
  always @* begin
    nxt_mask = mask_ff;
    if (param_change)
      nxt_mask = mask_ff & `EVF_KEEP_MASK;
    else if (mask_write_cmd && mask_ok && mask_arg[7:0] == 8'h00)
      nxt_mask = mask_ff & `EVF_KEEP_MASK;
    else if (mask_write_cmd && mask_ok)
      nxt_mask = mask_arg[7:0];
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= `EVF_RESET;
      mask_ff  <= `EVM_RESET;
    end else begin
      // Set wins over clear for every hardware event
      if (flag_clr)
        flags_ff <= ((flags_ff & `EVF_KEEP_MASK) | ev_set)
                    & `EVF_USED_MASK;
      else
        flags_ff <= (flags_ff | ev_set) & `EVF_USED_MASK;
      mask_ff <= nxt_mask;
    end
  end

  // Query replies
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reply_valid <= 1'b0;
      reply_data  <= 8'h00;
    end else begin
      reply_valid <= flags_query_cmd || mask_query_cmd;
      if (flags_query_cmd)
        reply_data <= flags_ff & `EVF_USED_MASK;
      else if (mask_query_cmd)
        reply_data <= mask_ff;
    end
  end

  // Summary bit and status byte
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      event_summary_bit <= 1'b0;
      status_summary    <= 8'h00;
    end else begin
      event_summary_bit <= summary_of(flags_ff, mask_ff);
      status_summary    <= {2'h0, summary_of(flags_ff, mask_ff),
                            5'h00};
    end
  end

  // Error reports, overflow ahead of range
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      error_valid <= 1'b0;
      error_code  <= `ERR_NONE;
    end else begin
      error_valid <= ovf_ff || range_err;
      if (ovf_ff)
        error_code <= `ERR_INPUT_FULL;
      else if (range_err)
        error_code <= `ERR_OUT_OF_RANGE;
    end
  end

endmodule // remote_serial_status_unit

// ===== bench/remote_serial_status_unit_assertions.sv
/* Port checker for the remote serial status unit.
   Sees only the unit's ports; bound to every instance below. */
`timescale 1ns/1ns
module rssu_checker (
  // Clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // Inputs watched
  input wire        flags_query_cmd,
  input wire        mask_query_cmd,
  input wire        mask_write_cmd,
  input wire [15:0] mask_arg,
  input wire        remote_cmd,
  input wire        release_to_panel_cmd,
  input wire        rx_valid,
  input wire        cts_in,
  // Outputs watched
  input wire        reply_valid,
  input wire [7:0]  reply_data,
  input wire        error_valid,
  input wire [7:0]  error_code,
  input wire        event_summary_bit,
  input wire [7:0]  status_summary,
  input wire        handshake_sel,
  input wire        rts_out,
  input wire        tx_enable,
  input wire        link_active_led,
  input wire [3:0]  panel_keys_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_query_reply: assert property (flags_query_cmd |=> reply_valid)
    else $error("flag query gave no reply");
  chk_unused_zero: assert property (reply_valid && $past(flags_query_cmd)
    && !$past(mask_query_cmd) |-> !reply_data[6] && !reply_data[1])
    else $error("unused flag bits set");
  chk_range_code: assert property (mask_write_cmd && mask_arg > 16'h00FF
    |=> error_valid && error_code == 8'h86)
    else $error("range error not reported");
  chk_full_cause: assert property (error_valid && error_code == 8'hB5
    |-> $past(rx_valid, 2))
    else $error("buffer full without word");
  chk_summary_pos: assert property (status_summary[5]
    == event_summary_bit)
    else $error("summary not in status bit 5");
  chk_rts_free: assert property (!handshake_sel && !$past(handshake_sel)
    && !$past(handshake_sel, 2) |-> rts_out)
    else $error("rts low without flow control");
  chk_cts_hold: assert property ((!cts_in)[*5] ##0 handshake_sel
    && $past(handshake_sel, 5) |-> !tx_enable)
    else $error("sending while cts off");
  chk_remote_led: assert property (remote_cmd ##1 !release_to_panel_cmd
    |=> link_active_led)
    else $error("remote state not shown");
  chk_keys_masked: assert property (link_active_led
    |-> panel_keys_out == 4'h0)
    else $error("panel keys pass in remote");
endmodule // rssu_checker

bind remote_serial_status_unit rssu_checker u_chk (.clk_sys, .resetn,
  .flags_query_cmd, .mask_query_cmd, .mask_write_cmd, .mask_arg,
  .remote_cmd, .release_to_panel_cmd, .rx_valid, .cts_in, .reply_valid,
  .reply_data, .error_valid, .error_code, .event_summary_bit,
  .status_summary, .handshake_sel, .rts_out, .tx_enable, .link_active_led,
  .panel_keys_out);

// ===== bench/pc_link_model.sv
/* Computer end of the serial link: offers words, drives clear-to-send.
   Assumes the bench sets its controls at the falling edge. */
`timescale 1ns/1ns
module pc_link_model (
  // Unit side
  input  wire       clk_sys,
  input  wire       rts_out,
  input  wire       rx_ready,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        cts_in,
  // Bench controls
  input  wire       send_en,
  input  wire       pace_rts,
  input  wire       cts_level
);
  reg       took_ff;
  reg [7:0] next_word;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    cts_in = 1'b1;
    took_ff = 1'b0;
    next_word = 8'h00;
  end
  always @(posedge clk_sys)
    took_ff <= rx_valid & rx_ready;
  always @(negedge clk_sys) begin
    cts_in <= cts_level;
    if (!(rx_valid && !took_ff && pace_rts)) begin
      if (send_en && (!pace_rts || rts_out)) begin
        rx_valid <= 1'b1;
        rx_data <= next_word;
        next_word <= next_word + 8'h01;
      end else begin
        // Released line shows no stale word
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule // pc_link_model

// ===== bench/remote_serial_status_unit_bench.sv
/* Self-checking bench for the remote serial status unit.
   Assumes the checker is bound and the link model stands at the far side. */
`timescale 1ns/1ns
module remote_serial_status_unit_bench;
  reg        clk_sys, resetn, nv_valid, nv_handshake, menu_handshake;
  reg        send_en, pace_rts, cts_level, tx_request, panel_release_key;
  reg        rx_out_ready, cmp_rx;
  reg [1:0]  menu_speed, nv_speed;
  reg [3:0]  panel_keys;
  reg [13:0] cmd;
  reg [15:0] mask_arg;
  reg [31:0] seed;
  reg [7:0]  event_flags, msk, last_err, next_rx;
  integer    n_errors, comparisons, i, n_nvw;
  wire       nv_write, nv_handshake_out;
  wire [1:0] nv_speed_out;
  wire [19:0] bit_cycles;
  wire       rts_out, rx_ready, rx_valid, rx_out_valid, tx_enable, cts_in;
  wire       link_active_led, reply_valid, event_summary_bit, error_valid;
  wire       handshake_sel;
  wire [7:0] rx_data, rx_out_data, reply_data, status_summary, error_code;
  wire [1:0] speed_sel;
  wire [3:0] panel_keys_out;

  remote_serial_status_unit dut (.clk_sys, .resetn,
    .speed_menu_key(cmd[12]), .handshake_menu_key(cmd[13]), .menu_speed,
    .menu_handshake, .nv_valid, .nv_speed, .nv_handshake, .nv_write,
    .nv_speed_out, .nv_handshake_out, .cts_in, .rts_out, .speed_sel,
    .handshake_sel, .bit_cycles, .rx_valid, .rx_data, .rx_ready,
    .rx_out_valid, .rx_out_data, .rx_out_ready, .tx_request, .tx_enable,
    .remote_cmd(cmd[0]), .release_to_panel_cmd(cmd[1]),
    .keypad_lockout_cmd(cmd[2]), .panel_release_key, .panel_keys,
    .link_active_led, .panel_keys_out, .clear_status_cmd(cmd[3]),
    .flags_query_cmd(cmd[4]), .mask_write_cmd(cmd[5]), .mask_arg,
    .mask_query_cmd(cmd[6]), .op_complete_cmd(cmd[7]), .command_error(cmd[8]),
    .run_fault(cmd[9]), .device_error(cmd[10]), .query_error(cmd[11]),
    .reply_valid, .reply_data, .event_summary_bit, .status_summary,
    .error_valid, .error_code);
  pc_link_model pc (.clk_sys, .rts_out, .rx_ready, .rx_valid, .rx_data,
    .cts_in, .send_en, .pace_rts, .cts_level);

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] evbit(input integer k);
    case (k)
      0: evbit = 8'h01;
      1: evbit = 8'h20;
      2: evbit = 8'h10;
      3: evbit = 8'h08;
      default: evbit = 8'h14;
    endcase
  endfunction
  task chk(input [8*12:1] what, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (exp !== got) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task pulse(input integer k);
    begin
      cmd[k] = 1'b1;
      tick(1);
      cmd[k] = 1'b0;
      tick(1);
    end
  endtask
  task query(input integer k, input [7:0] exp);
    begin
      pulse(k);
      chk("reply", exp, reply_data);
    end
  endtask
  task wmask(input [15:0] v);
    begin
      mask_arg = v;
      pulse(5);
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  always @(posedge clk_sys) begin
    if (error_valid)
      last_err <= error_code;
    if (nv_write)
      n_nvw <= n_nvw + 1;
    if (cmp_rx && rx_out_valid && rx_out_ready) begin
      chk("rx word", next_rx, rx_out_data);
      next_rx <= next_rx + 8'h01;
    end
  end

  initial begin
    #200000;
    n_errors = n_errors + 1;
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {cmd, mask_arg, menu_speed, nv_valid, nv_speed, nv_handshake} = 0;
    {menu_handshake, send_en, tx_request, panel_release_key} = 4'h0;
    {pace_rts, cts_level, rx_out_ready, cmp_rx, panel_keys} = 8'hF0;
    {n_errors, comparisons, last_err, next_rx} = 0;
    n_nvw = 0;
    seed = 32'h0D2F;
    resetn = 1'b0;
    tick(5);
    resetn = 1'b1;
    event_flags = 8'h80;
    msk = 8'h00;
    chk("speed", 3, speed_sel);
    chk("rts", 1, rts_out);
    query(4, event_flags);
    query(6, msk);
    $display("defaults done");
    for (i = 0; i < 5; i = i + 1) begin
      pulse(7 + i);
      tick(3);
      event_flags = event_flags | evbit(i);
      query(4, event_flags);
      event_flags = 8'h80;
      query(4, event_flags);
    end
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      msk = (seed[7:0] == 8'h00) ? (msk & 8'h80) : seed[7:0];
      wmask({8'h00, seed[7:0]});
      query(6, msk);
      pulse(7 + i % 5);
      event_flags = event_flags | evbit(i % 5);
      chk("summary", |(event_flags & msk), event_summary_bit);
      chk("stb bit", |(event_flags & msk), status_summary[5]);
    end
    wmask(16'h0100);
    tick(1);
    chk("range code", 134, last_err);
    query(6, msk);
    query(4, event_flags | 8'h10);
    pulse(3);
    event_flags = 8'h80;
    query(4, event_flags);
    $display("event flags done");
    wmask(16'h00FF);
    pulse(8);
    for (i = 0; i < 4; i = i + 1) begin
      menu_speed = i;
      pulse(12);
      tick(2);
      chk("speed", i, speed_sel);
      chk("nv speed", i, nv_speed_out);
      chk("bit cycles", 250000000 / (1200 << i), bit_cycles);
    end
    chk("nv writes", 4, n_nvw);
    query(4, event_flags);
    query(6, 8'h80);
    menu_handshake = 1'b1;
    pulse(13);
    tick(2);
    chk("handshake", 1, handshake_sel);
    chk("nv hs out", 1, nv_handshake_out);
    send_en = 1'b1;
    for (i = 0; i < 80; i = i + 1) begin
      seed = lfsr(seed);
      {tx_request, panel_keys, rx_out_ready} = seed[5:0];
      tick(1);
    end
    rx_out_ready = 1'b0;
    tick(8);
    chk("rts full", 0, rts_out);
    chk("rx ready", 0, rx_ready);
    send_en = 1'b0;
    rx_out_ready = 1'b1;
    tick(10);
    chk("drained", pc.next_word, next_rx);
    tx_request = 1'b1;
    cts_level = 1'b0;
    tick(6);
    chk("tx held", 0, tx_enable);
    cts_level = 1'b1;
    tick(6);
    chk("tx on", 1, tx_enable);
    menu_handshake = 1'b0;
    pulse(13);
    {pace_rts, cmp_rx, rx_out_ready, cts_level, send_en} = 5'h01;
    tick(6);
    send_en = 1'b0;
    tick(4);
    chk("rts none", 1, rts_out);
    chk("tx free", 1, tx_enable);
    chk("full code", 181, last_err);
    rx_out_ready = 1'b1;
    $display("link done");
    pulse(0);
    tick(1);
    chk("led on", 1, link_active_led);
    menu_speed = 2'h1;
    pulse(12);
    tick(2);
    chk("menu ignored", 3, speed_sel);
    panel_release_key = 1'b1;
    tick(5);
    chk("key release", 0, link_active_led);
    panel_release_key = 1'b0;
    pulse(0);
    pulse(2);
    panel_release_key = 1'b1;
    tick(5);
    chk("locked", 1, link_active_led);
    panel_release_key = 1'b0;
    pulse(1);
    tick(1);
    chk("cmd release", 0, link_active_led);
    pulse(0);
    {nv_valid, nv_speed, nv_handshake} = 4'hD;
    resetn = 1'b0;
    tick(5);
    resetn = 1'b1;
    tick(4);
    chk("nv speed", 2, speed_sel);
    chk("nv handshake", 1, handshake_sel);
    chk("pwr release", 0, link_active_led);
    $display("remote done");
    close_out;
  end
endmodule // remote_serial_status_unit_bench
